//--- logic/ibd_defines.vh
// Constants shared by the input bit delay and sampling block.
`ifndef IBD_DEFINES_VH
`define IBD_DEFINES_VH
// First and last local stream skew register addresses.
`define IBD_LOCAL_FIRST 8'h23
`define IBD_LOCAL_LAST 8'h2A
// First and last backplane stream skew register addresses.
`define IBD_BP_FIRST 8'h63
`define IBD_BP_LAST 8'h6A
// Skew code field position inside a 16-bit register word.
`define IBD_CODE_MSB 4
`define IBD_CODE_LSB 0
// Reset value of every skew code.
`define IBD_CODE_RESET 5'h00
// Clock cycles per serial bit, one per quarter bit.
`define IBD_QUARTERS 4
// Quarter-bit history kept per stream; fixes total latency.
`define IBD_HIST_DEPTH 36
// Quarter count from frame boundary to the first emitted bit.
`define IBD_FIRST_EMIT 6'h23
// Word count of the output buffer.
`define IBD_FIFO_DEPTH 4
`endif

//--- logic/ibd_top.v
// Per-stream input bit delay and sampling point logic with its ports.
`include "ibd_defines.vh"

// Small buffer with valid and ready on both sides.
module ibd_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = `IBD_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire clock, // System clock.
  input wire rst_n, // Synchronised active-low reset.
  input wire [WIDTH-1:0] in_data, // Word to store.
  input wire in_valid, // Source offers a word.
  output wire in_ready, // Buffer has room.
  output reg [WIDTH-1:0] out_data, // Oldest stored word.
  output wire out_valid, // Buffer holds a word.
  input wire out_ready // Sink takes the word.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage.
  reg [AW-1:0] wr_reg; // Write pointer.
  reg [AW-1:0] rd_reg; // Read pointer.
  reg [AW:0] cnt_reg; // Number of stored words.
  wire push; // A word enters this cycle.
  wire pop; // A word leaves this cycle.

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Pointers and fill count; push and pop may share a cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Storage needs no reset; only counted words are ever shown.
  always @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Output word is read combinationally from the head slot.
  always @* begin
    out_data = mem[rd_reg];
  end
endmodule // ibd_fifo

// One stream: pin synchroniser, quarter-bit history and sampling tap.
module ibd_lane (
  input wire clock, // System clock, one tick per quarter bit.
  input wire rst_n, // Synchronised active-low reset.
  input wire din, // Serial stream pin.
  input wire [4:0] code, // This stream's skew code.
  input wire mode, // Sampling point select mode.
  output wire bit_out // Bit seen at the chosen sampling moment.
);
  reg s1_reg; // First synchroniser stage, read only by the second.
  reg s2_reg; // Second synchroniser stage.
  reg s3_reg; // Third synchroniser stage.
  reg st_reg; // Accepted level.
  reg [`IBD_HIST_DEPTH-1:0] hist_reg; // Quarter-bit samples, newest at 0.
  wire [1:0] sp_rot; // Rotated sampling point code.
  wire [2:0] spoint; // Sampling quarter, 1 to 4.
  wire [5:0] dly_q; // Delay in quarter bits.
  wire [5:0] age; // History tap.
  // Three stages; a new level counts only once stages two and three agree.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      st_reg <= 1'b1;
      hist_reg <= {`IBD_HIST_DEPTH{1'b1}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        st_reg <= s3_reg;
      end
      hist_reg <= {hist_reg[`IBD_HIST_DEPTH-2:0], st_reg};
    end
  end

  // Codes 00,01,10,11 map to quarters 3,4,1,2 in integer mode.
  assign sp_rot = code[1:0] + 2'h2;
  // Quarter mode keeps the three-quarter point whatever the code.
  assign spoint = mode ? ({1'b0, sp_rot} + 3'h1) : 3'h3;
  // Integer mode uses whole bits; quarter mode counts quarters.
  assign dly_q = mode ? {1'b0, code[4:2], 2'h0}
                      : {1'b0, code};
  // Later sampling means a younger sample at the fixed emit moment.
  assign age = `IBD_FIRST_EMIT - {3'h0, spoint} - dly_q;
  assign bit_out = hist_reg[age];
endmodule // ibd_lane

// Top: register port, sixteen lanes, frame timing and output buffer.
module ibd_top (
  input wire clock, // System clock, 20 MHz.
  input wire rstn, // Asynchronous active-low reset.
  input wire sampling_point_select_mode, // Control bit, same clock.
  input wire [7:0] local_in, // Local serial input streams.
  input wire [7:0] backplane_in, // Backplane serial input streams.
  input wire frame_n, // Frame pulse pin, active low.
  input wire cs_n, // Register port chip select, active low.
  input wire ds_n, // Register port data strobe, active low.
  input wire rw, // High reads, low writes.
  input wire [7:0] addr, // Register address.
  input wire [15:0] data_in, // Data bus input.
  output reg [15:0] data_out, // Data bus output.
  output wire data_oe, // High while driving the data bus.
  output wire ack_n, // Access acknowledge, active low.
  output wire [15:0] bit_data, // Bits, local in 7:0, backplane 15:8.
  output wire bit_first, // Word holds frame bit zero.
  output wire bit_valid, // Output word valid.
  input wire bit_ready, // Sink takes the word.
  output reg overrun, // A word was lost to a full buffer.
  input wire overrun_clear // Clears the overrun flag.
);
  reg rst_s1_reg; // Reset release, first stage.
  reg rst_s2_reg; // Reset release, second stage.
  wire rst_n; // Reset used by the design.
  reg [4:0] code_reg [0:15]; // Skew codes, local 0..7, backplane 8..15.
  reg a1_reg; // Access synchroniser, first stage.
  reg a2_reg; // Access synchroniser, second stage.
  reg a3_reg; // Access synchroniser, third stage.
  reg acc_reg; // Accepted access level.
  reg done_reg; // Access has been served.
  reg rd_reg; // Access being served is a read.
  reg f1_reg; // Frame synchroniser, first stage.
  reg f2_reg; // Frame synchroniser, second stage.
  reg f3_reg; // Frame synchroniser, third stage.
  reg fr_reg; // Accepted frame level, active low.
  reg fr_old_reg; // Previous accepted frame level.
  reg [1:0] phase_reg; // Quarter within the bit.
  reg [5:0] qcnt_reg; // Quarters since frame, saturating.
  reg [15:0] lane_reg; // Registered lane bits.
  reg emit_reg; // Lane bits are ready to enter the buffer.
  reg first_reg; // Emitted bits are bit zero of a frame.
  wire [15:0] lane_bits; // Lane taps.
  wire [79:0] codes; // All codes, flattened.
  wire hit_local; // Address is a local skew register.
  wire hit_bp; // Address is a backplane skew register.
  wire [7:0] idx_local; // Local register offset.
  wire [7:0] idx_bp; // Backplane register offset.
  wire [3:0] sel; // Selected code slot.
  wire fifo_ready; // Buffer has room.
  wire frame_edge; // Frame boundary seen.
  integer i; // Reset loop index.
  // Reset is applied at once but released through two flip-flops.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;
  // Address decode; each stream has its own address in order.
  assign hit_local = (addr >= `IBD_LOCAL_FIRST) &&
                     (addr <= `IBD_LOCAL_LAST);
  assign hit_bp = (addr >= `IBD_BP_FIRST) && (addr <= `IBD_BP_LAST);
  assign idx_local = addr - `IBD_LOCAL_FIRST;
  assign idx_bp = addr - `IBD_BP_FIRST;
  assign sel = hit_local ? {1'b0, idx_local[2:0]}
                         : {1'b1, idx_bp[2:0]};

  // Port strobes are asynchronous, so they pass three stages.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a1_reg <= 1'b0;
      a2_reg <= 1'b0;
      a3_reg <= 1'b0;
      acc_reg <= 1'b0;
    end else begin
      a1_reg <= ~cs_n & ~ds_n;
      a2_reg <= a1_reg;
      a3_reg <= a2_reg;
      if (a2_reg == a3_reg) begin
        acc_reg <= a3_reg;
      end
    end
  end

  // One action per strobe; address and data must hold while strobed.
  // Upper bits are not stored, so they always read back as zero.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      rd_reg <= 1'b0;
      data_out <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        code_reg[i] <= `IBD_CODE_RESET;
      end
    end else if (acc_reg & ~done_reg) begin
      done_reg <= 1'b1;
      rd_reg <= rw;
      data_out <= 16'h0000;
      if (hit_local | hit_bp) begin
        if (rw) begin
          data_out[`IBD_CODE_MSB:`IBD_CODE_LSB] <= code_reg[sel];
        end else begin
          // Only the addressed stream changes; others run on.
          code_reg[sel] <= data_in[`IBD_CODE_MSB:`IBD_CODE_LSB];
        end
      end
    end else if (~acc_reg) begin
      done_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
  end

  // Unmapped reads drive zero; unmapped writes are acknowledged only.
  assign ack_n = ~done_reg;
  assign data_oe = done_reg & rd_reg;
  // Frame pulse passes the same three stages as the stream pins.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      f1_reg <= 1'b1;
      f2_reg <= 1'b1;
      f3_reg <= 1'b1;
      fr_reg <= 1'b1;
      fr_old_reg <= 1'b1;
    end else begin
      f1_reg <= frame_n;
      f2_reg <= f1_reg;
      f3_reg <= f2_reg;
      if (f2_reg == f3_reg) begin
        fr_reg <= f3_reg;
      end
      fr_old_reg <= fr_reg;
    end
  end
  assign frame_edge = fr_old_reg & ~fr_reg;
  // Bit timing restarts at the boundary, so delays count from it.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
      qcnt_reg <= 6'h00;
    end else if (frame_edge) begin
      phase_reg <= 2'h1;
      qcnt_reg <= 6'h01;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (qcnt_reg != 6'h3F) begin
        qcnt_reg <= qcnt_reg + 6'h01;
      end
    end
  end

  // Flatten the codes so each lane sees only its own register.
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gen_lane
      assign codes[g*5+4:g*5] = code_reg[g];
      // Every lane shares the one mode bit.
      ibd_lane u_lane (
        .clock(clock),
        .rst_n(rst_n),
        .din(g < 8 ? local_in[g % 8] : backplane_in[g % 8]),
        .code(codes[g*5+4:g*5]),
        .mode(sampling_point_select_mode),
        .bit_out(lane_bits[g])
      );
    end
  endgenerate
  // Taps are caught once per bit, at the last quarter of the period.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lane_reg <= 16'h0000;
      emit_reg <= 1'b0;
      first_reg <= 1'b0;
    end else begin
      emit_reg <= (phase_reg == 2'h3) && !frame_edge;
      if ((phase_reg == 2'h3) && !frame_edge) begin
        lane_reg <= lane_bits;
        first_reg <= (qcnt_reg == `IBD_FIRST_EMIT);
      end
    end
  end

  // The serial line cannot be stalled, so a full buffer drops a word.
  // The loss is flagged; a new loss wins over a clear in one cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (emit_reg & ~fifo_ready) begin
      overrun <= 1'b1;
    end else if (overrun_clear) begin
      overrun <= 1'b0;
    end
  end
  ibd_fifo #(
    .WIDTH(17),
    .DEPTH(`IBD_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data({first_reg, lane_reg}),
    .in_valid(emit_reg),
    .in_ready(fifo_ready),
    .out_data({bit_first, bit_data}),
    .out_valid(bit_valid),
    .out_ready(bit_ready)
  );
endmodule // ibd_top

//--- tb/ibd_assertions.sv
// Port assertions for the input bit delay and sampling block.
module ibd_assertions (
  input wire clock, // Clock.
  input wire rstn, // Reset, low.
  input wire cs_n, // Select, low.
  input wire ds_n, // Strobe, low.
  input wire [15:0] data_out, // Read data.
  input wire data_oe, // Bus drive.
  input wire ack_n, // Ack, low.
  input wire [15:0] bit_data, // Head word.
  input wire bit_first, // Frame bit zero.
  input wire bit_valid, // Head valid.
  input wire bit_ready, // Sink takes.
  input wire overrun, // Lost word.
  input wire overrun_clear // Clear.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // An access starts when both strobes are low.
  sequence strobe_start;
    $rose(!cs_n && !ds_n);
  endsequence
  // An access ends when either strobe rises.
  sequence strobe_end;
    $rose(cs_n || ds_n);
  endsequence
  ack_bound_a: assert property (strobe_start |-> ##[3:6] !ack_n)
    else $error("ack late");
  ack_hold_a: assert property (!cs_n && !ds_n && !ack_n |=> !ack_n)
    else $error("ack dropped early");
  ack_release_a: assert property (strobe_end |-> ##[2:6] ack_n)
    else $error("ack stuck");
  read_drive_a: assert property (data_oe |-> !ack_n)
    else $error("drive without ack");
  upper_zero_a: assert property (data_oe |-> data_out[15:5] == 11'h000)
    else $error("upper bits set");
  reset_idle_a: assert property ($rose(rstn) |->
    ack_n && !data_oe && !bit_valid && !overrun) else $error("reset state");
  head_stable_a: assert property (bit_valid && !bit_ready |=>
    bit_valid && $stable(bit_data) && $stable(bit_first))
    else $error("head moved");
  overrun_keep_a: assert property (overrun && !overrun_clear |=> overrun)
    else $error("flag lost");
  overrun_cause_a: assert property ($rose(overrun) |->
    $past(bit_valid && !bit_ready)) else $error("flag without stall");
endmodule // ibd_assertions

bind ibd_top ibd_assertions chk_u (.clock(clock), .rstn(rstn),
  .cs_n(cs_n), .ds_n(ds_n), .data_out(data_out), .data_oe(data_oe),
  .ack_n(ack_n), .bit_data(bit_data), .bit_first(bit_first),
  .bit_valid(bit_valid), .bit_ready(bit_ready), .overrun(overrun),
  .overrun_clear(overrun_clear));

//--- tb/ibd_src.sv
// Stream source: frame pulse and quarter-rate bit patterns.
module ibd_src #(
  parameter [63:0] PAT = 64'h0000_0000_0000_0000 // Pattern.
) (
  input wire clock, // Clock.
  input wire rstn, // Reset, low.
  output reg frame_n, // Frame pulse.
  output reg [7:0] local_in, // Local streams.
  output reg [7:0] backplane_in // Backplane streams.
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [6:0] q_reg; // Quarter count in the frame.
  reg [6:0] q_next; // Next quarter count.
  integer j; // Stream index.
  // Next quarter count, shared by the count and the pattern index.
  always @* begin
    q_next = q_reg + 7'h01;
  end
  // Pattern levels last at least two quarters, so the pin filter passes them,
  // yet a sample one quarter off still reads wrong at many places.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q_reg <= 7'h00;
      frame_n <= 1'h1;
      local_in <= 8'h00;
      backplane_in <= 8'h00;
    end else begin
      q_reg <= q_next;
      frame_n <= (q_next > 7'h03);
      for (j = 0; j < 8; j = j + 1) begin
        local_in[j] <= PAT[(q_next + 7 * j) % 64];
        backplane_in[j] <= PAT[(q_next + 7 * j + 56) % 64];
      end
    end
  end
endmodule // ibd_src

//--- tb/ibd_top_tb.sv
// Self-checking bench for the input bit delay and sampling block.
`include "ibd_defines.vh"
module ibd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Every bit doubled; a lone quarter would be eaten by the pin filter.
  localparam [63:0] PAT = 64'hF30F_CC33_C33C_F00F; // Stream pattern.
  localparam [31:0] UNMAP = 32'h226B_622B; // Holes around the blocks.
  reg clock = 1'h0;
  reg rstn = 1'h0;
  reg mode = 1'h0;
  reg cs_n = 1'h1;
  reg ds_n = 1'h1;
  reg rw = 1'h1;
  reg [7:0] addr = 8'h00;
  reg [15:0] data_in = 16'h0000;
  reg bit_ready = 1'h1;
  reg overrun_clear = 1'h0;
  wire frame_n, data_oe, ack_n, bit_first, bit_valid, overrun;
  wire [7:0] local_in, backplane_in;
  wire [15:0] data_out, bit_data;
  integer n_errors = 0;
  integer samples_checked = 0;
  always #25 clock = ~clock;
  ibd_src #(.PAT(PAT)) src_u (.clock(clock), .rstn(rstn),
    .frame_n(frame_n), .local_in(local_in), .backplane_in(backplane_in));
  ibd_top dut_u (.clock(clock), .rstn(rstn),
    .sampling_point_select_mode(mode), .local_in(local_in),
    .backplane_in(backplane_in), .frame_n(frame_n), .cs_n(cs_n),
    .ds_n(ds_n), .rw(rw), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ack_n(ack_n),
    .bit_data(bit_data), .bit_first(bit_first), .bit_valid(bit_valid),
    .bit_ready(bit_ready), .overrun(overrun),
    .overrun_clear(overrun_clear));
  task give_verdict;
    begin
      $display("Checked %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task check(input [15:0] seen, input [15:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  // Bounded wait for the acknowledge level; a hang ends the run.
  task wait_ack(input lvl);
    integer i;
    begin
      i = 0;
      while (ack_n !== lvl && i < 20) begin
        @(posedge clock);
        i = i + 1;
      end
      if (ack_n !== lvl) begin
        n_errors = n_errors + 1;
        give_verdict;
      end
    end
  endtask
  // One access; the strobe stands until the acknowledge is seen.
  task access(input w, input [7:0] a, input [15:0] d, output [15:0] q);
    begin
      @(posedge clock);
      #2;
      cs_n = 1'h0;
      ds_n = 1'h0;
      rw = ~w;
      addr = a;
      data_in = d;
      wait_ack(1'h0);
      q = data_out;
      check(data_oe, {15'h0000, ~w});
      #2;
      cs_n = 1'h1;
      ds_n = 1'h1;
      wait_ack(1'h1);
    end
  endtask
  function [7:0] reg_addr(input integer j);
    reg_addr = (j < 8) ? `IBD_LOCAL_FIRST + 8'(j) : `IBD_BP_FIRST + 8'(j - 8);
  endfunction
  function [4:0] code(input integer j, input [4:0] p);
    code = 5'(2 * j) + p;
  endfunction
  // Reset values, address map, reserved bits and unmapped holes.
  task test_regs;
    integer j;
    reg [15:0] q;
    begin
      for (j = 0; j < 16; j = j + 1) begin
        access(1'h0, reg_addr(j), 16'h0000, q);
        check(q, 16'h0000);
        access(1'h1, reg_addr(j), 16'(j), q);
      end
      for (j = 0; j < 4; j = j + 1) begin
        access(1'h1, UNMAP[8 * j +: 8], 16'h001F, q);
        access(1'h0, UNMAP[8 * j +: 8], 16'h0000, q);
        check(q, 16'h0000);
      end
      for (j = 0; j < 16; j = j + 1) begin
        access(1'h0, reg_addr(j), 16'h0000, q);
        check(q, 16'(j));
      end
    end
  endtask
  // Distinct codes on all streams; first eight bits of the second frame checked.
  task test_timing(input m, input [4:0] p);
    integer j, k, f, n, s, d, c;
    reg [15:0] w, q;
    begin
      @(posedge clock);
      #2;
      mode = m;
      for (j = 0; j < 16; j = j + 1) begin
        access(1'h1, reg_addr(j), {11'h000, code(j, p)}, q);
      end
      f = 0;
      k = 8;
      n = 0;
      // The second frame start is clear of the register changes.
      while ((f < 2 || k < 8) && n < 800) begin
        @(negedge clock);
        n = n + 1;
        if (bit_valid === 1'h1 && bit_first === 1'h1) begin
          f = f + 1;
          k = (f == 2) ? 0 : 8;
        end
        if (bit_valid === 1'h1 && f == 2 && k < 8) begin
          for (j = 0; j < 16; j = j + 1) begin
            c = code(j, p);
            s = m ? (c % 4 + 2) % 4 + 1 : 3;
            d = m ? 4 * (c / 4) : c;
            w[j] = PAT[(4 * k + s + d - 1 + 7 * j) % 64];
          end
          check(bit_data, w);
          k = k + 1;
        end
      end
      if (k < 8) begin
        n_errors = n_errors + 1;
        give_verdict;
      end
    end
  endtask
  // Stall the sink until words are lost, then drain and clear the flag.
  task test_overrun;
    integer n;
    begin
      @(posedge clock);
      #2;
      bit_ready = 1'h0;
      repeat (48) @(posedge clock);
      check(overrun, 16'h0001);
      #2;
      bit_ready = 1'h1;
      n = 0;
      while (bit_valid === 1'h1 && n < 16) begin
        @(negedge clock);
        n = n + 1;
      end
      check(bit_valid, 16'h0000);
      check(overrun, 16'h0001);
      @(posedge clock);
      #2;
      overrun_clear = 1'h1;
      @(posedge clock);
      #2;
      overrun_clear = 1'h0;
      repeat (2) @(posedge clock);
      check(overrun, 16'h0000);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #2;
    rstn = 1'h1;
    repeat (3) @(posedge clock);
    test_regs;
    test_timing(1'h0, 5'h00);
    test_timing(1'h0, 5'h01);
    test_timing(1'h1, 5'h00);
    test_timing(1'h1, 5'h01);
    test_overrun;
    give_verdict;
  end
endmodule // ibd_top_tb
